// ===== scim_pkg.sv
package scim_pkg;
	localparam int ADDR_W = 18;
	// register word indices; byte address is four times the index
	localparam logic [15:0] IDX_DATA = 16'h449E;
	localparam logic [15:0] IDX_MODE = 16'h44AA;
	localparam logic [15:0] IDX_CMD = 16'h4480;
	localparam logic [15:0] IDX_ACK = 16'h4481;
	localparam logic [15:0] IDX_STAT = 16'h4482;
	localparam logic [15:0] IDX_RLIN = 16'h4483;
	localparam logic [15:0] IDX_REXP = 16'h4484;
	localparam logic [15:0] IDX_IMASK = 16'h4485;
	localparam logic [15:0] IDX_IFLAG = 16'h4486;
	localparam logic [1:0] MODE_I2C = 2'h3;
	// segment_command_reg bits
	localparam int CMD_START = 0;
	localparam int CMD_SEND = 1;
	localparam int CMD_RECV = 2;
	localparam int CMD_STOP = 3;
	localparam int CMD_W = 4;
	// bus_status_reg bits
	localparam int ST_CMDFIN = 0;
	localparam int ST_TXFIN = 1;
	localparam int ST_RXFIN = 2;
	localparam int ST_RXNAK = 3;
	localparam int ST_W = 4;
	// event flag and mask bits
	localparam int EV_CMD = 0;
	localparam int EV_TX = 1;
	localparam int EV_TXNAK = 2;
	localparam int EV_RX = 3;
	localparam int EV_RXOVF = 4;
	localparam int EV_TXUND = 5;
	localparam int EV_W = 6;
	// clock rates in MHz for the 24 MHz reference tick
	localparam logic [7:0] CLK_MHZ = 8'd125;
	localparam logic [7:0] REF_MHZ = 8'd24;
	localparam int CNT_W = 20;
	// last half-period step of each segment, and the first step of the byte's ack slot
	localparam logic [4:0] START_LAST = 5'h03;
	localparam logic [4:0] STOP_LAST = 5'h02;
	localparam logic [4:0] BYTE_LAST = 5'h11;
	localparam logic [4:0] BYTE_ACK = 5'h10;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {SEG_IDLE, SEG_START, SEG_STOP, SEG_BYTE} scim_seg_e;
endpackage : scim_pkg

// ===== scim_slave_model.sv
module scim_slave_model #(parameter logic [6:0] ADDR = 7'h2A) (
	// sampling clock
	input wire logic aclk,
	// resolved bus levels and slow-answer request
	input wire logic scl,
	input wire logic sda,
	input wire logic stretch,
	// pulls and what was observed
	output logic scl_oe,
	output logic sda_oe,
	output logic [7:0] got_byte,
	output logic master_ack
);
	timeunit 1ns;
	timeprecision 1ps;
	logic scl_q, sda_q, sel, rd, first;
	logic [3:0] cnt;
	logic [7:0] sr;
	logic [4:0] hold;
	initial begin
		{scl_q, sda_q, sel, rd, first, scl_oe, sda_oe, master_ack} = '0;
		{cnt, sr, hold, got_byte} = '0;
	end
	// only ever pulls low; pull-ups give the high level
	always @(posedge aclk) begin
		scl_q <= scl;
		sda_q <= sda;
		if (hold != 5'h0) hold <= hold - 5'h1;
		else scl_oe <= 1'b0;
		if (scl && scl_q && sda_q && !sda) begin
			cnt <= 4'h0;
			first <= 1'b1;
			sda_oe <= 1'b0;
		end else if (scl && scl_q && !sda_q && sda) begin
			sel <= 1'b0;
			sda_oe <= 1'b0;
		end else if (!scl_q && scl) begin
			if (cnt == 4'h8) begin
				master_ack <= !sda;
				// a nack ends the read, so the bus is free for stop
				if (rd && sda) sel <= 1'b0;
				cnt <= 4'h0;
			end else begin
				sr <= {sr[6:0], sda};
				cnt <= cnt + 4'h1;
			end
		end else if (scl_q && !scl) begin
			// slow answer: hold the clock low for about 20 cycles after its fall
			if (stretch) begin
				scl_oe <= 1'b1;
				hold <= 5'd20;
			end
			if (cnt == 4'h8 && first) begin
				sel <= sr[7:1] == ADDR;
				rd <= sr[0];
				sda_oe <= sr[7:1] == ADDR;
				first <= 1'b0;
			end else if (cnt == 4'h8) begin
				if (!rd) got_byte <= sr;
				sda_oe <= sel && !rd;
			end else begin
				sda_oe <= sel && rd && !first && !got_byte[3'd7 - cnt[2:0]];
			end
		end
	end
endmodule : scim_slave_model

// ===== scim_top.sv
// Functional notes
// - engine runs only while mode field is three
// - master only, never answers as slave
// - no arbitration, sole master on bus
// - lines only pulled low, pull-ups external
// - half bit equals (lin+1)*2^exp reference ticks
// - one command bit at a time only
// - receive ack slot follows ack select bit
// - one-byte transmit and receive buffers, software
// - start/stop clear bit, set command finished
// - transmit shifts byte, clears bit, flags done
// - receive clocks byte, clears bit, flags done
// - status shows slave nack or ack
// - six sticky events feed interrupt line
// - event needs its mask bit enabled
// - data write pushes, data read pops
//
// Implementation choice: the AXI4-Lite interface to the registers.
module scim_top (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write channels
	input wire logic [scim_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// axi4-lite read channels
	input wire logic [scim_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// pin setup strap, high when four-wire pins are selected
	input wire logic four_wire_sel,
	// open-collector bus lines
	input wire logic master_clock_line_i,
	output logic master_clock_line_o,
	output logic master_clock_line_oe,
	input wire logic master_data_line_i,
	output logic master_data_line_o,
	output logic master_data_line_oe,
	// masked event line
	output logic serial_irq
);
	import scim_pkg::*;

	logic aw_got_q, aw_got_d, w_got_q, w_got_d, bvalid_q, bvalid_d;
	logic awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
	logic rvalid_q, rvalid_d;
	logic [ADDR_W-1:0] awaddr_q, awaddr_d;
	logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
	logic [3:0] wstrb_q, wstrb_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic [15:0] widx, ridx, rd_val;
	logic wr_do, rd_pop;

	logic [1:0] mode_q, mode_d;
	logic ack_sel_q, ack_sel_d, tx_full_q, tx_full_d, rx_full_q, rx_full_d;
	logic [3:0] rlin_q, rlin_d, rexp_q, rexp_d;
	logic [CMD_W-1:0] cmd_q, cmd_d;
	logic [ST_W-1:0] stat_q, stat_d;
	logic [EV_W-1:0] imask_q, imask_d, iflag_q, iflag_d, ev, iclr;
	logic [7:0] tx_q, tx_d, rx_q, rx_d, shift_q, shift_d;
	scim_seg_e seg_q, seg_d;
	logic [4:0] step_q, step_d;
	logic [CNT_W-1:0] cnt_q, cnt_d, lim;
	logic [6:0] acc_q, acc_d;
	logic [7:0] acc_sum;
	logic ref_tick, half_end, done;
	logic scl_dr_q, scl_dr_d, sda_dr_q, sda_dr_d, irq_q, irq_d;
	logic scl_s1_q, scl_s2_q, sda_s1_q, sda_s2_q;

	function automatic logic mapped(input logic [15:0] idx);
		mapped = idx inside {IDX_DATA, IDX_MODE, IDX_CMD, IDX_ACK, IDX_STAT,
			IDX_RLIN, IDX_REXP, IDX_IMASK, IDX_IFLAG};
	endfunction : mapped

	// returns {scl pull, sda pull} for a step; scl_h keeps clock as it was
	function automatic logic [1:0] drv(input scim_seg_e s, input logic [4:0] st,
			input logic [7:0] sh, input logic snd, input logic ack, input logic scl_h);
		logic d;
		d = (st < BYTE_ACK) ? (snd & ~sh[7]) : (~snd & ack);
		case (s)
			SEG_START: begin
				case (st)
					5'h00: drv = {scl_h, 1'b0};
					5'h01: drv = 2'b00;
					5'h02: drv = 2'b01;
					default: drv = 2'b11;
				endcase
			end
			SEG_STOP: begin
				case (st)
					5'h00: drv = 2'b11;
					5'h01: drv = 2'b01;
					default: drv = 2'b00;
				endcase
			end
			SEG_BYTE: drv = {~st[0], d};
			default: drv = 2'b00;
		endcase
	endfunction : drv

	assign widx = awaddr_q[ADDR_W-1:2];
	assign ridx = araddr[ADDR_W-1:2];
	assign wr_do = aw_got_q & w_got_q & ~bvalid_q;
	assign rd_pop = arvalid & arready_q & (ridx == IDX_DATA);

	// register read mux
	always_comb begin
		rd_val = '0;
		case (ridx)
			IDX_DATA: rd_val[7:0] = rx_q;
			IDX_MODE: rd_val[1:0] = mode_q;
			IDX_CMD: rd_val[CMD_W-1:0] = cmd_q;
			IDX_ACK: rd_val[0] = ack_sel_q;
			IDX_STAT: rd_val = {10'h000, rx_full_q, tx_full_q, stat_q};
			IDX_RLIN: rd_val[3:0] = rlin_q;
			IDX_REXP: rd_val[3:0] = rexp_q;
			IDX_IMASK: rd_val[EV_W-1:0] = imask_q;
			IDX_IFLAG: rd_val[EV_W-1:0] = iflag_q;
			default: rd_val = '0;
		endcase
	end

	// axi4-lite slave: address and data taken in either order
	always_comb begin
		aw_got_d = aw_got_q;
		awaddr_d = awaddr_q;
		w_got_d = w_got_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		if (awvalid && awready_q) begin
			aw_got_d = 1'b1;
			awaddr_d = awaddr;
		end
		if (wvalid && wready_q) begin
			w_got_d = 1'b1;
			wdata_d = wdata;
			wstrb_d = wstrb;
		end
		if (bvalid_q && bready)
			bvalid_d = 1'b0;
		if (wr_do) begin
			aw_got_d = 1'b0;
			w_got_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = mapped(widx) ? RESP_OKAY : RESP_SLVERR;
		end
		if (rvalid_q && rready)
			rvalid_d = 1'b0;
		if (arvalid && arready_q) begin
			rvalid_d = 1'b1;
			rdata_d = {16'h0000, rd_val};
			rresp_d = mapped(ridx) ? RESP_OKAY : RESP_SLVERR;
		end
		awready_d = ~aw_got_d;
		wready_d = ~w_got_d;
		arready_d = ~rvalid_d;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= RESP_OKAY;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			arready_q <= 1'b0;
		end else begin
			aw_got_q <= aw_got_d;
			w_got_q <= w_got_d;
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
			awready_q <= awready_d;
			wready_q <= wready_d;
			arready_q <= arready_d;
		end
	end

	// reference tick: 24 of every 125 cycles, spread evenly
	assign acc_sum = {1'b0, acc_q} + REF_MHZ;
	assign ref_tick = acc_sum >= CLK_MHZ;
	assign lim = CNT_W'(({16'h0000, rlin_q} + 20'h00001) << rexp_q);

	// registers and segment engine
	always_comb begin
		mode_d = mode_q;
		ack_sel_d = ack_sel_q;
		rlin_d = rlin_q;
		rexp_d = rexp_q;
		imask_d = imask_q;
		cmd_d = cmd_q;
		stat_d = stat_q;
		tx_d = tx_q;
		tx_full_d = tx_full_q;
		rx_d = rx_q;
		rx_full_d = rx_full_q;
		seg_d = seg_q;
		step_d = step_q;
		shift_d = shift_q;
		cnt_d = cnt_q;
		scl_dr_d = scl_dr_q;
		sda_dr_d = sda_dr_q;
		ev = '0;
		iclr = '0;
		half_end = 1'b0;
		done = 1'b0;
		acc_d = ref_tick ? 7'(acc_sum - CLK_MHZ) : acc_sum[6:0];
		if (wr_do && wstrb_q[0]) begin
			case (widx)
				IDX_MODE: mode_d = wdata_q[1:0];
				IDX_DATA: begin
					tx_d = wdata_q[7:0];
					tx_full_d = 1'b1;
				end
				IDX_CMD: begin
					// refused unless idle, in bus mode, two-wire pins, one bit
					if (mode_q == MODE_I2C && !four_wire_sel && cmd_q == '0 &&
							$onehot(wdata_q[CMD_W-1:0]))
						cmd_d = wdata_q[CMD_W-1:0];
				end
				IDX_ACK: ack_sel_d = wdata_q[0];
				IDX_RLIN: rlin_d = wdata_q[3:0];
				IDX_REXP: rexp_d = wdata_q[3:0];
				IDX_IMASK: imask_d = wdata_q[EV_W-1:0];
				IDX_IFLAG: iclr = wdata_q[EV_W-1:0];
				default: ;
			endcase
		end
		if (rd_pop)
			rx_full_d = 1'b0;
		if (seg_q == SEG_IDLE && cmd_q != '0) begin
			step_d = '0;
			cnt_d = '0;
			stat_d = '0;
			if (cmd_q[CMD_START])
				seg_d = SEG_START;
			else if (cmd_q[CMD_STOP])
				seg_d = SEG_STOP;
			else
				seg_d = SEG_BYTE;
			if (cmd_q[CMD_SEND]) begin
				shift_d = tx_q;
				tx_full_d = 1'b0;
				ev[EV_TXUND] = ~tx_full_q;
			end
		end else if (seg_q != SEG_IDLE && ref_tick && !(!scl_dr_q && !scl_s2_q)) begin
			// clock held while a slave stretches the released line
			if (cnt_q == lim - 20'h00001) begin
				cnt_d = '0;
				half_end = 1'b1;
			end else begin
				cnt_d = cnt_q + 20'h00001;
			end
		end
		if (half_end) begin
			step_d = step_q + 5'h01;
			if (seg_q == SEG_BYTE && step_q[0] && step_q < BYTE_ACK)
				shift_d = {shift_q[6:0], sda_s2_q};
			done = (seg_q == SEG_START && step_q == START_LAST) ||
				(seg_q == SEG_STOP && step_q == STOP_LAST) ||
				(seg_q == SEG_BYTE && step_q == BYTE_LAST);
		end
		if (done) begin
			cmd_d = '0;
			seg_d = SEG_IDLE;
			if (seg_q == SEG_BYTE) begin
				scl_dr_d = 1'b1;
				stat_d[ST_RXNAK] = sda_s2_q;
				if (cmd_q[CMD_SEND]) begin
					stat_d[ST_TXFIN] = 1'b1;
					ev[EV_TX] = 1'b1;
					ev[EV_TXNAK] = sda_s2_q;
				end else begin
					stat_d[ST_RXFIN] = 1'b1;
					ev[EV_RX] = 1'b1;
					if (rx_full_d) begin
						ev[EV_RXOVF] = 1'b1;
					end else begin
						rx_d = shift_q;
						rx_full_d = 1'b1;
					end
				end
			end else begin
				stat_d[ST_CMDFIN] = 1'b1;
				ev[EV_CMD] = 1'b1;
			end
		end else if (seg_d != SEG_IDLE) begin
			{scl_dr_d, sda_dr_d} = drv(seg_d, step_d, shift_d, cmd_q[CMD_SEND],
				ack_sel_q, scl_dr_q);
		end
		if (mode_q != MODE_I2C) begin
			cmd_d = '0;
			seg_d = SEG_IDLE;
			scl_dr_d = 1'b0;
			sda_dr_d = 1'b0;
		end
		iflag_d = (iflag_q & ~iclr) | ev;
		irq_d = |(iflag_q & imask_q);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_q <= '0;
			ack_sel_q <= 1'b0;
			rlin_q <= '0;
			rexp_q <= '0;
			imask_q <= '0;
			iflag_q <= '0;
			cmd_q <= '0;
			stat_q <= '0;
			tx_q <= '0;
			tx_full_q <= 1'b0;
			rx_q <= '0;
			rx_full_q <= 1'b0;
			seg_q <= SEG_IDLE;
			step_q <= '0;
			shift_q <= '0;
			cnt_q <= '0;
			acc_q <= '0;
			scl_dr_q <= 1'b0;
			sda_dr_q <= 1'b0;
			irq_q <= 1'b0;
			scl_s1_q <= 1'b1;
			scl_s2_q <= 1'b1;
			sda_s1_q <= 1'b1;
			sda_s2_q <= 1'b1;
		end else begin
			mode_q <= mode_d;
			ack_sel_q <= ack_sel_d;
			rlin_q <= rlin_d;
			rexp_q <= rexp_d;
			imask_q <= imask_d;
			iflag_q <= iflag_d;
			cmd_q <= cmd_d;
			stat_q <= stat_d;
			tx_q <= tx_d;
			tx_full_q <= tx_full_d;
			rx_q <= rx_d;
			rx_full_q <= rx_full_d;
			seg_q <= seg_d;
			step_q <= step_d;
			shift_q <= shift_d;
			cnt_q <= cnt_d;
			acc_q <= acc_d;
			scl_dr_q <= scl_dr_d;
			sda_dr_q <= sda_dr_d;
			irq_q <= irq_d;
			scl_s1_q <= master_clock_line_i;
			scl_s2_q <= scl_s1_q;
			sda_s1_q <= master_data_line_i;
			sda_s2_q <= sda_s1_q;
		end
	end

	assign awready = awready_q;
	assign wready = wready_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign arready = arready_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;
	// output data is always low; only the enables move
	assign master_clock_line_o = 1'b0;
	assign master_data_line_o = 1'b0;
	assign master_clock_line_oe = scl_dr_q;
	assign master_data_line_oe = sda_dr_q;
	assign serial_irq = irq_q;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_byte_done;
		done && seg_q == SEG_BYTE;
	endsequence
	sequence s_ack_low;
		seg_q == SEG_BYTE && half_end && step_q == BYTE_ACK - 5'h01 && !cmd_q[CMD_SEND];
	endsequence

	a_mode_gate: assert property (mode_q != MODE_I2C |=> seg_q == SEG_IDLE && !scl_dr_q)
		else $error("engine active outside bus mode");
	a_cmd_onehot: assert property ($onehot0(cmd_q))
		else $error("more than one command bit set");
	a_cmd_clear: assert property (done |=> cmd_q == '0 && seg_q == SEG_IDLE)
		else $error("command bit not cleared at segment end");
	a_cmdfin_set: assert property (done && seg_q != SEG_BYTE |=> stat_q[ST_CMDFIN] && iflag_q[EV_CMD])
		else $error("command finished flag missing");
	a_txfin_set: assert property (s_byte_done and cmd_q[CMD_SEND] |=> stat_q[ST_TXFIN])
		else $error("transmit finished flag missing");
	a_rx_capture: assert property (s_byte_done and !cmd_q[CMD_SEND] |=> stat_q[ST_RXFIN] && rx_full_q)
		else $error("received byte not held");
	a_nak_status: assert property (s_byte_done |=> stat_q[ST_RXNAK] == $past(sda_s2_q))
		else $error("nack status wrong");
	a_ack_drive: assert property (s_ack_low |=> sda_dr_q == ack_sel_q && scl_dr_q)
		else $error("ack slot drive wrong");
	a_half_bound: assert property (seg_q != SEG_IDLE |-> cnt_q < lim)
		else $error("half period counter overrun");
	a_data_push: assert property (wr_do && wstrb_q[0] && widx == IDX_DATA |=> tx_full_q)
		else $error("data write did not fill buffer");
	a_irq_mask: assert property (|(iflag_q & imask_q) |=> serial_irq)
		else $error("masked event not raised");
endmodule : scim_top

// ===== testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import scim_pkg::*;
	localparam logic [6:0] SADDR = 7'h2A;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [17:0] awaddr = '0;
	logic [17:0] araddr = '0;
	logic [31:0] wdata = '0;
	logic [3:0] wstrb = '0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic four_wire_sel = 1'b0, stretch = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, serial_irq;
	logic m_scl_oe, m_sda_oe, s_scl_oe, s_sda_oe, master_ack;
	logic [1:0] bresp, rresp, br, rr;
	logic [31:0] rdata, d, rnd;
	logic [7:0] got_byte, b;
	logic scl_w, sda_w;
	int err_count = 0, num_checks = 0, seed = 75037, cycles = 0, hc = 0, hw = 0, e;
	logic [15:0] regs[6] = '{IDX_DATA, IDX_MODE, IDX_CMD, IDX_STAT, IDX_IMASK, IDX_IFLAG};
	logic [3:0] bad[6] = '{4'h3, 4'h5, 4'h6, 4'h9, 4'hC, 4'hF};
	// standard, fast, strict fast, then short rates to keep the run brief
	int lins[5] = '{14, 14, 15, 0, 1};
	int exps[5] = '{3, 1, 1, 0, 1};
	// open-collector lines with pull-ups
	assign scl_w = !(m_scl_oe || s_scl_oe);
	assign sda_w = !(m_sda_oe || s_sda_oe);
	scim_top dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
		.wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready, .four_wire_sel, .master_clock_line_i(scl_w),
		.master_clock_line_o(), .master_clock_line_oe(m_scl_oe), .master_data_line_i(sda_w),
		.master_data_line_o(), .master_data_line_oe(m_sda_oe), .serial_irq);
	scim_slave_model #(.ADDR(SADDR)) slave (.aclk, .scl(scl_w), .sda(sda_w), .stretch,
		.scl_oe(s_scl_oe), .sda_oe(s_sda_oe), .got_byte, .master_ack);
	initial begin
		forever #4 aclk = ~aclk;
	end
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : final_report
	// scl high time of the last clock pulse on the wire
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (scl_w) hc <= hc + 1;
		else begin
			if (hc != 0) hw <= hc;
			hc <= 0;
		end
		if (cycles == 50000) begin
			err_count++;
			final_report();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			$display("Error at %0t: got %h expected %h", $time, got, exp);
			err_count++;
		end
	endtask : chk
	task automatic axw(input logic [15:0] idx, input logic [31:0] v);
		@(posedge aclk);
		awaddr <= {idx, 2'b00};
		wdata <= v;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		// ends when bvalid is seen; without a response only the bench timeout ends this wait
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		br = bresp;
		bready <= 1'b0;
	endtask : axw
	task automatic axr(input logic [15:0] idx, output logic [31:0] v);
		@(posedge aclk);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		v = rdata;
		rr = rresp;
		rready <= 1'b0;
	endtask : axr
	// launch one segment and poll until its command bit clears
	task automatic seg(input logic [3:0] c);
		logic [31:0] v;
		axw(IDX_CMD, {28'h0, c});
		do begin
			axr(IDX_CMD, v);
		end while (v[3:0] !== 4'h0);
		chk(v, 32'h0);
	endtask : seg
	function automatic int half_cyc(int lin, int ex);
		return ((lin + 1) << ex) * 125 / 24;
	endfunction : half_cyc
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		foreach (regs[i]) begin
			axr(regs[i], d);
			chk(d, 32'h0);
		end
		axr(16'h4000, d);
		chk({rr, d[29:0]}, {RESP_SLVERR, 30'h0});
		axw(16'h4000, 32'h1);
		chk({30'h0, br}, {30'h0, RESP_SLVERR});
		$display("test registers done");
		for (int m = 0; m < 3; m++) begin
			axw(IDX_MODE, 32'(m));
			axr(IDX_MODE, d);
			chk(d, 32'(m));
			axw(IDX_CMD, 32'h1);
			axr(IDX_CMD, d);
			chk({d[30:0], m_scl_oe}, 32'h0);
			axw(IDX_MODE, 32'h0);
		end
		axw(IDX_MODE, {30'h0, MODE_I2C});
		axw(IDX_RLIN, 32'h0);
		axw(IDX_REXP, 32'h0);
		foreach (bad[i]) begin
			axw(IDX_CMD, {28'h0, bad[i]});
			axr(IDX_CMD, d);
			chk(d, 32'h0);
		end
		four_wire_sel <= 1'b1;
		axw(IDX_CMD, 32'h1);
		axr(IDX_CMD, d);
		chk(d, 32'h0);
		four_wire_sel <= 1'b0;
		$display("test refusals done");
		seg(4'h1);
		axr(IDX_STAT, d);
		chk(d, 32'h1);
		chk({30'h0, scl_w, sda_w}, 32'h0);
		axr(IDX_IFLAG, d);
		chk(d & 32'h1, 32'h1);
		axw(IDX_DATA, {24'h0, SADDR, 1'b0});
		seg(4'h2);
		axr(IDX_STAT, d);
		chk(d, 32'h2);
		for (int k = 0; k < 5; k++) begin
			axw(IDX_RLIN, 32'(lins[k]));
			axw(IDX_REXP, 32'(exps[k]));
			stretch <= (k == 4);
			rnd = $random(seed);
			b = rnd[7:0];
			axw(IDX_DATA, {24'h0, b});
			seg(4'h2);
			chk({24'h0, got_byte}, {24'h0, b});
			e = half_cyc(lins[k], exps[k]);
			chk({31'h0, hw >= e - 2 && hw <= e + 2}, 32'h1);
		end
		stretch <= 1'b0;
		$display("test transmit done");
		seg(4'h1);
		axw(IDX_DATA, {24'h0, SADDR, 1'b1});
		seg(4'h2);
		axw(IDX_ACK, 32'h1);
		seg(4'h4);
		axr(IDX_STAT, d);
		chk(d, 32'h24);
		chk({31'h0, master_ack}, 32'h1);
		axw(IDX_ACK, 32'h0);
		seg(4'h4);
		chk({31'h0, master_ack}, 32'h0);
		axr(IDX_IFLAG, d);
		chk(d & 32'h18, 32'h18);
		axr(IDX_DATA, d);
		chk(d, {24'h0, b});
		axr(IDX_STAT, d);
		chk(d & 32'h20, 32'h0);
		seg(4'h8);
		chk({30'h0, scl_w, sda_w}, 32'h3);
		axr(IDX_STAT, d);
		chk(d, 32'h1);
		$display("test receive done");
		seg(4'h1);
		axw(IDX_DATA, {24'h0, 5'h1E, 2'h1, 1'b0});
		seg(4'h2);
		axr(IDX_STAT, d);
		chk(d & 32'hA, 32'hA);
		seg(4'h2);
		axr(IDX_IFLAG, d);
		chk(d & 32'h26, 32'h26);
		seg(4'h8);
		chk({31'h0, serial_irq}, 32'h0);
		axw(IDX_IMASK, 32'h20);
		repeat (3) @(posedge aclk);
		chk({31'h0, serial_irq}, 32'h1);
		axw(IDX_IFLAG, 32'h20);
		repeat (3) @(posedge aclk);
		chk({31'h0, serial_irq}, 32'h0);
		$display("test events done");
		final_report();
	end
endmodule : testbench
